// ===== core/hcb_pkg.sv
// Constants, field layouts and carrier types for the hub configuration bank slice.
// Assumes a single 200 MHz core clock and 8-bit registers at offsets 25h to 29h.
package hcb_pkg;
	localparam int NUM_PORTS = 4;

	// Register offsets
	localparam logic [7:0] ADDR_DEV_CFG3 = 8'h25;
	localparam logic [7:0] ADDR_LEGACY = 8'h26;
	localparam logic [7:0] ADDR_SID_LO = 8'h27;
	localparam logic [7:0] ADDR_SID_HI = 8'h28;
	localparam logic [7:0] ADDR_BBPID_LO = 8'h29;

	// Reset values of the control registers
	localparam logic [7:0] RST_DEV_CFG3 = 8'h00;
	localparam logic [3:0] RST_LEGACY = 4'h0;

	// Field positions in device_config_three
	localparam int BIT_SS_SUPPRESS = 4;
	localparam int BIT_SLOW_RATE = 2;
	localparam int BIT_VEND_EXCL = 1;
	localparam int BIT_ALL_DIV = 0;

	// Bits that hold a register flop and a fuse; the rest read zero
	localparam logic [7:0] CFG3_LIVE_MASK = 8'h17;

	// Serial master clock timing
	localparam int SYS_CLK_KHZ = 200000;
	localparam int SLOW_SCL_KHZ = 100;
	localparam int FAST_SCL_KHZ = 400;
	localparam int SCL_CNT_W = 11;
	// Least half period, rounded up to whole core cycles
	localparam logic [SCL_CNT_W-1:0] SLOW_HALF_CYC =
		SCL_CNT_W'((SYS_CLK_KHZ + 2 * SLOW_SCL_KHZ - 1) / (2 * SLOW_SCL_KHZ));
	localparam logic [SCL_CNT_W-1:0] FAST_HALF_CYC =
		SCL_CNT_W'((SYS_CLK_KHZ + 2 * FAST_SCL_KHZ - 1) / (2 * FAST_SCL_KHZ));

	// Configuration access from the EEPROM loader or the SMBus slave
	typedef struct packed {
		logic we;
		logic re;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hcb_cfg_req_s;

	// Effective features after the fuse merge
	typedef struct packed {
		logic ss_suppress;
		logic slow_rate;
		logic vend_excl;
		logic all_div;
	} hcb_feat_s;

	// Automatic charger detection steps, divider modes from highest current
	typedef enum logic [5:0] {
		CHG_IDLE = 6'h01,
		CHG_DIV3 = 6'h02,
		CHG_DIV2 = 6'h04,
		CHG_DIV1 = 6'h08,
		CHG_VEND = 6'h10,
		CHG_DCP = 6'h20
	} hcb_chg_e;
endpackage

// ===== core/hcb_fuse_merge.sv
// Merges the stored configuration bits with the one-time fuse bits.
// Assumes the fuse bits are static levels from the fuse array.
`timescale 1ns/1ps
module hcb_fuse_merge (
	// Stored and fused bits
	input wire logic [7:0] reg_bits_i,
	input wire logic [7:0] fuse_bits_i,
	// Merged view
	output logic [7:0] merged_o
);
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_bit
			// Either source switches the feature on; a write can never mask a fuse
			if (hcb_pkg::CFG3_LIVE_MASK[gi]) begin : g_live
				assign merged_o[gi] = reg_bits_i[gi] | fuse_bits_i[gi]; // RL3 RL14
			end else begin : g_dead
				assign merged_o[gi] = 1'b0; // RL1
			end
		end
	endgenerate
endmodule // hcb_fuse_merge

// ===== core/hcb_charge_seq.sv
// Automatic charger detection stepper for one downstream port.
// Assumes the port logic pulses step_i when the current mode was not accepted.
`timescale 1ns/1ps
module hcb_charge_seq (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// Sequence control
	input wire logic auto_en_i,
	input wire logic start_i,
	input wire logic step_i,
	input wire logic stop_i,
	// Features
	input wire logic all_div_i,
	input wire logic vend_excl_i,
	// Mode being tried
	output hcb_pkg::hcb_chg_e mode_o
);
	hcb_pkg::hcb_chg_e state_q;
	hcb_pkg::hcb_chg_e state_d;
	hcb_pkg::hcb_chg_e after_div;

	// The vendor mode is skipped outright when excluded
	assign after_div = vend_excl_i ? hcb_pkg::CHG_DCP : hcb_pkg::CHG_VEND; // RL6

	always_comb begin
		state_d = state_q;
		case (state_q)
			hcb_pkg::CHG_IDLE: if (start_i) begin
				state_d = all_div_i ? hcb_pkg::CHG_DIV3 : after_div; // RL7
			end
			hcb_pkg::CHG_DIV3: if (step_i) begin
				state_d = hcb_pkg::CHG_DIV2; // RL7
			end
			hcb_pkg::CHG_DIV2: if (step_i) begin
				state_d = hcb_pkg::CHG_DIV1; // RL7
			end
			hcb_pkg::CHG_DIV1: if (step_i) begin
				state_d = after_div; // RL7
			end
			hcb_pkg::CHG_VEND: if (step_i || vend_excl_i) begin
				state_d = hcb_pkg::CHG_DCP; // RL6
			end
			default: state_d = state_q;
		endcase
		if (stop_i || !auto_en_i) begin
			state_d = hcb_pkg::CHG_IDLE;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= hcb_pkg::CHG_IDLE;
		end else if (ce_i) begin
			state_q <= state_d;
		end
	end

	assign mode_o = state_q;
endmodule // hcb_charge_seq

// ===== core/hcb_bank.sv
// Configuration bank slice at offsets 25h to 29h of the hub, with its feature outputs.
// Assumes one access request per cycle from the EEPROM loader or SMBus slave, taken
// when ce_i is high; reads answer one cycle later from flops.
//
// Behaviour
// RL1: Bits seven to five read zero, ignore writes
// RL2: Suppress bit hides 5Gbps and disables superspeed hub
// RL3: Readback of bits 4,2,1,0 ORs fuse
// RL4: Bit two selects 100kHz host serial transfers
// RL5: EEPROM reads at 400k unless fuse selects slow
// RL6: Exclusion bit drops vendor mode from charger sequence
// RL7: All-divider bit tries dividers, highest first, before DCP
// RL8: Legacy mask bit restricts its port to legacy
// RL9: Legacy mask writable only with removable override
// RL10: Legacy mask overrides the port-used flag
// RL11: Alternate-mode identifier is 27h low, 28h high
// RL12: Billboard product low byte lives at 29h
// RL13: Identifier registers reset to defaults, then overwritable
// RL14: Fuse bits are fixed inputs, never cleared
`timescale 1ns/1ps
module hcb_bank #(
	// Identifier defaults; these values are arbitrary
	parameter logic [7:0] SID_LO_RST = 8'h5A,
	parameter logic [7:0] SID_HI_RST = 8'hA5,
	parameter logic [7:0] BBPID_LO_RST = 8'h3C
) (
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// Configuration access
	input wire hcb_pkg::hcb_cfg_req_s cfg_req_i,
	output logic [7:0] cfg_rdata_o,
	output logic cfg_rvalid_o,
	// Straps and fuses
	input wire logic [7:0] fuse_bits_i,
	input wire logic custom_removable_override_i,
	// Serial master
	input wire logic eeprom_busy_i,
	output logic host_xfer_slow_o,
	output logic eeprom_xfer_slow_o,
	output logic [hcb_pkg::SCL_CNT_W-1:0] scl_half_cycles_o,
	// Superspeed control
	output logic hub_superspeed_suppress_o,
	output logic ss_speed_advertise_o,
	output logic ss_hub_enable_o,
	// Ports
	input wire logic [hcb_pkg::NUM_PORTS-1:0] port_used_i,
	output logic [hcb_pkg::NUM_PORTS-1:0] port_legacy_only_mask_o,
	output logic [hcb_pkg::NUM_PORTS-1:0] port_ss_enable_o,
	// Charger detection
	input wire logic auto_charge_en_i,
	input wire logic [hcb_pkg::NUM_PORTS-1:0] chg_start_i,
	input wire logic [hcb_pkg::NUM_PORTS-1:0] chg_step_i,
	input wire logic [hcb_pkg::NUM_PORTS-1:0] chg_stop_i,
	output hcb_pkg::hcb_chg_e [hcb_pkg::NUM_PORTS-1:0] chg_mode_o,
	// Identifiers
	output logic [15:0] alt_mode_sid_o,
	output logic [7:0] billboard_product_low_o
);
	logic [7:0] cfg3_q;
	logic [7:0] cfg3_rd;
	logic [3:0] legacy_q;
	logic [7:0] sid_lo_q;
	logic [7:0] sid_hi_q;
	logic [7:0] bbpid_lo_q;
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic [7:0] rd_addr_q;
	logic wr_cfg3;
	logic wr_legacy;
	logic wr_sid_lo;
	logic wr_sid_hi;
	logic wr_bbpid;
	hcb_pkg::hcb_feat_s feat_q;
	logic eeprom_slow_q;
	logic [hcb_pkg::SCL_CNT_W-1:0] scl_q;
	logic [hcb_pkg::NUM_PORTS-1:0] port_ss_q;

	// Write decode
	always_comb begin
		wr_cfg3 = 1'b0;
		wr_legacy = 1'b0;
		wr_sid_lo = 1'b0;
		wr_sid_hi = 1'b0;
		wr_bbpid = 1'b0;
		if (cfg_req_i.we) begin
			if (cfg_req_i.addr == hcb_pkg::ADDR_DEV_CFG3) begin
				wr_cfg3 = 1'b1;
			end else if (cfg_req_i.addr == hcb_pkg::ADDR_LEGACY) begin
				wr_legacy = custom_removable_override_i; // RL9
			end else if (cfg_req_i.addr == hcb_pkg::ADDR_SID_LO) begin
				wr_sid_lo = 1'b1;
			end else if (cfg_req_i.addr == hcb_pkg::ADDR_SID_HI) begin
				wr_sid_hi = 1'b1;
			end else if (cfg_req_i.addr == hcb_pkg::ADDR_BBPID_LO) begin
				wr_bbpid = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg3_q <= hcb_pkg::RST_DEV_CFG3;
		end else if (ce_i && wr_cfg3) begin
			// Reserved bits never store anything
			cfg3_q <= cfg_req_i.wdata & hcb_pkg::CFG3_LIVE_MASK; // RL1
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			legacy_q <= hcb_pkg::RST_LEGACY;
		end else if (ce_i && wr_legacy) begin
			legacy_q <= cfg_req_i.wdata[3:0]; // RL9
		end
	end

	// Identifier registers; an EEPROM image or SMBus host replaces the defaults
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sid_lo_q <= SID_LO_RST; // RL13
			sid_hi_q <= SID_HI_RST; // RL13
			bbpid_lo_q <= BBPID_LO_RST; // RL13
		end else if (ce_i) begin
			if (wr_sid_lo) begin
				sid_lo_q <= cfg_req_i.wdata; // RL11
			end
			if (wr_sid_hi) begin
				sid_hi_q <= cfg_req_i.wdata; // RL11
			end
			if (wr_bbpid) begin
				bbpid_lo_q <= cfg_req_i.wdata; // RL12
			end
		end
	end

	hcb_fuse_merge i_hcb_fuse_merge (
		.reg_bits_i(cfg3_q),
		.fuse_bits_i(fuse_bits_i),
		.merged_o(cfg3_rd)
	);

	// Read mux; unmapped offsets read zero
	always_comb begin
		rdata_d = 8'h00;
		if (cfg_req_i.addr == hcb_pkg::ADDR_DEV_CFG3) begin
			rdata_d = cfg3_rd; // RL3
		end else if (cfg_req_i.addr == hcb_pkg::ADDR_LEGACY) begin
			rdata_d = {4'h0, legacy_q};
		end else if (cfg_req_i.addr == hcb_pkg::ADDR_SID_LO) begin
			rdata_d = sid_lo_q;
		end else if (cfg_req_i.addr == hcb_pkg::ADDR_SID_HI) begin
			rdata_d = sid_hi_q;
		end else if (cfg_req_i.addr == hcb_pkg::ADDR_BBPID_LO) begin
			rdata_d = bbpid_lo_q;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_q <= 8'h00;
			rd_addr_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else if (ce_i) begin
			rvalid_q <= cfg_req_i.re;
			if (cfg_req_i.re) begin
				rdata_q <= rdata_d;
				rd_addr_q <= cfg_req_i.addr;
			end
		end
	end

	// Features are registered so the charger sequencers and feature outputs share one copy; scl_q samples cfg3_rd itself
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			feat_q <= '0;
		end else if (ce_i) begin
			feat_q.ss_suppress <= cfg3_rd[hcb_pkg::BIT_SS_SUPPRESS]; // RL2
			feat_q.slow_rate <= cfg3_rd[hcb_pkg::BIT_SLOW_RATE]; // RL4
			feat_q.vend_excl <= cfg3_rd[hcb_pkg::BIT_VEND_EXCL]; // RL6
			feat_q.all_div <= cfg3_rd[hcb_pkg::BIT_ALL_DIV]; // RL7
		end
	end

	// EEPROM loads follow the fuse alone, so a host write cannot slow the boot load
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			eeprom_slow_q <= 1'b0;
			scl_q <= hcb_pkg::FAST_HALF_CYC;
		end else if (ce_i) begin
			eeprom_slow_q <= fuse_bits_i[hcb_pkg::BIT_SLOW_RATE]; // RL5
			if (eeprom_busy_i) begin
				scl_q <= fuse_bits_i[hcb_pkg::BIT_SLOW_RATE] ? hcb_pkg::SLOW_HALF_CYC
					: hcb_pkg::FAST_HALF_CYC; // RL5
			end else begin
				scl_q <= cfg3_rd[hcb_pkg::BIT_SLOW_RATE] ? hcb_pkg::SLOW_HALF_CYC
					: hcb_pkg::FAST_HALF_CYC; // RL4
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			port_ss_q <= '0;
		end else if (ce_i) begin
			port_ss_q <= port_used_i & ~legacy_q; // RL8 RL10
		end
	end

	genvar gp;
	generate
		for (gp = 0; gp < hcb_pkg::NUM_PORTS; gp++) begin : g_port
			hcb_charge_seq i_hcb_charge_seq (
				.clk_sys_i(clk_sys_i),
				.rstn_i(rstn_i),
				.ce_i(ce_i),
				.auto_en_i(auto_charge_en_i),
				.start_i(chg_start_i[gp]),
				.step_i(chg_step_i[gp]),
				.stop_i(chg_stop_i[gp]),
				.all_div_i(feat_q.all_div),
				.vend_excl_i(feat_q.vend_excl),
				.mode_o(chg_mode_o[gp])
			);
		end
	endgenerate

	assign cfg_rdata_o = rdata_q;
	assign cfg_rvalid_o = rvalid_q;
	assign host_xfer_slow_o = feat_q.slow_rate; // RL4
	assign eeprom_xfer_slow_o = eeprom_slow_q;
	assign scl_half_cycles_o = scl_q;
	assign hub_superspeed_suppress_o = feat_q.ss_suppress;
	assign ss_speed_advertise_o = ~feat_q.ss_suppress; // RL2
	assign ss_hub_enable_o = ~feat_q.ss_suppress; // RL2
	assign port_legacy_only_mask_o = legacy_q; // RL8
	assign port_ss_enable_o = port_ss_q;
	assign alt_mode_sid_o = {sid_hi_q, sid_lo_q}; // RL11
	assign billboard_product_low_o = bbpid_lo_q; // RL12

	// Checks
	property p_rsvd_zero;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(rvalid_q && rd_addr_q == hcb_pkg::ADDR_DEV_CFG3) |-> (rdata_q[7:5] == 3'h0);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved cfg3 bits not zero"); // RL1

	property p_ss_off;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(ce_i && cfg3_rd[hcb_pkg::BIT_SS_SUPPRESS]) |=> (!ss_hub_enable_o && !ss_speed_advertise_o);
	endproperty
	a_ss_off: assert property (p_ss_off) else $error("superspeed not suppressed"); // RL2

	property p_or_read;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(ce_i && cfg_req_i.re && cfg_req_i.addr == hcb_pkg::ADDR_DEV_CFG3) |=>
			(rdata_q[4:0] == ($past(cfg3_q[4:0]) | ($past(fuse_bits_i[4:0]) & 5'h17)));
	endproperty
	a_or_read: assert property (p_or_read) else $error("cfg3 readback not OR of fuse"); // RL3

	property p_host_rate;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(ce_i && !eeprom_busy_i) |=> (host_xfer_slow_o == (scl_half_cycles_o == 11'h3E8));
	endproperty
	a_host_rate: assert property (p_host_rate) else $error("host serial rate wrong"); // RL4

	property p_eeprom_rate;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(ce_i && eeprom_busy_i && !fuse_bits_i[hcb_pkg::BIT_SLOW_RATE]) |=>
			(scl_half_cycles_o == 11'h0FA && !eeprom_xfer_slow_o);
	endproperty
	a_eeprom_rate: assert property (p_eeprom_rate) else $error("eeprom not at fast rate"); // RL5

	property p_no_vendor;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(feat_q.vend_excl [*2]) |-> (chg_mode_o[0] != hcb_pkg::CHG_VEND
			&& chg_mode_o[1] != hcb_pkg::CHG_VEND && chg_mode_o[2] != hcb_pkg::CHG_VEND
			&& chg_mode_o[3] != hcb_pkg::CHG_VEND);
	endproperty
	a_no_vendor: assert property (p_no_vendor) else $error("excluded vendor mode tried"); // RL6

	sequence s_div_start;
		ce_i && auto_charge_en_i && feat_q.all_div && chg_start_i[0] && !chg_stop_i[0]
			&& chg_mode_o[0] == hcb_pkg::CHG_IDLE;
	endsequence
	sequence s_div_wait;
		ce_i && auto_charge_en_i && !chg_step_i[0] && !chg_stop_i[0];
	endsequence
	sequence s_div_step;
		ce_i && auto_charge_en_i && chg_step_i[0] && !chg_stop_i[0];
	endsequence
	property p_div_order;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		s_div_start ##1 s_div_wait ##1 s_div_step |=> (chg_mode_o[0] == hcb_pkg::CHG_DIV2)
			and ($past(chg_mode_o[0]) == hcb_pkg::CHG_DIV3);
	endproperty
	a_div_order: assert property (p_div_order) else $error("divider order wrong"); // RL7

	property p_port_ss;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		ce_i |=> (port_ss_enable_o == ($past(port_used_i) & ~$past(legacy_q)));
	endproperty
	a_port_ss: assert property (p_port_ss) else $error("legacy mask not applied"); // RL8 RL10

	property p_legacy_lock;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(cfg_req_i.we && cfg_req_i.addr == hcb_pkg::ADDR_LEGACY && !custom_removable_override_i)
			|=> (port_legacy_only_mask_o == $past(legacy_q));
	endproperty
	a_legacy_lock: assert property (p_legacy_lock) else $error("legacy mask written"); // RL9

	property p_sid_write;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(ce_i && cfg_req_i.we && cfg_req_i.addr == hcb_pkg::ADDR_SID_HI) |=>
			(alt_mode_sid_o[15:8] == $past(cfg_req_i.wdata));
	endproperty
	a_sid_write: assert property (p_sid_write) else $error("identifier high byte wrong"); // RL11

	property p_bbpid_write;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		(ce_i && cfg_req_i.we && cfg_req_i.addr == hcb_pkg::ADDR_BBPID_LO) |=>
			(billboard_product_low_o == $past(cfg_req_i.wdata));
	endproperty
	a_bbpid_write: assert property (p_bbpid_write) else $error("product low byte wrong"); // RL12

	property p_id_reset;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		$rose(rstn_i) |-> (alt_mode_sid_o == {SID_HI_RST, SID_LO_RST}
			&& billboard_product_low_o == BBPID_LO_RST);
	endproperty
	a_id_reset: assert property (p_id_reset) else $error("identifier reset default wrong"); // RL13

	sequence s_clear_write;
		ce_i && cfg_req_i.we && cfg_req_i.addr == hcb_pkg::ADDR_DEV_CFG3
			&& fuse_bits_i[hcb_pkg::BIT_SS_SUPPRESS];
	endsequence
	sequence s_read_back;
		ce_i && cfg_req_i.re && cfg_req_i.addr == hcb_pkg::ADDR_DEV_CFG3
			&& fuse_bits_i[hcb_pkg::BIT_SS_SUPPRESS];
	endsequence
	property p_fuse_sticks;
		@(posedge clk_sys_i) disable iff (!rstn_i)
		s_clear_write ##2 s_read_back |=> rdata_q[hcb_pkg::BIT_SS_SUPPRESS];
	endproperty
	a_fuse_sticks: assert property (p_fuse_sticks) else $error("fuse bit cleared by write"); // RL14
endmodule // hcb_bank

// ===== sim/hcb_cfg_src.sv
// Behavioural configuration source: an SMBus host or an EEPROM loader issuing byte accesses.
// Assumes the bank takes one request per enabled edge and answers reads one cycle later.
`timescale 1ns/1ps
module hcb_cfg_src (
	// Clock
	input wire logic clk_sys_i,
	// Access port
	output hcb_pkg::hcb_cfg_req_s cfg_req_o,
	input wire logic [7:0] cfg_rdata_i,
	input wire logic cfg_rvalid_i
);
	initial cfg_req_o = '0;

	// Released lines carry the inverse of the last byte, so a stale copy is never read
	task automatic idle(input logic [7:0] a, input logic [7:0] d);
		cfg_req_o <= '{we: 1'b0, re: 1'b0, addr: ~a, wdata: ~d};
	endtask

	// Loads or replaces one byte; taken at the next edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		cfg_req_o <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys_i);
		idle(a, d);
	endtask

	// Reads one byte; the valid flag stands for one cycle only, the data holds until the next read
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk_sys_i);
		cfg_req_o <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_sys_i);
		idle(a, 8'h00);
		#1;
		d = cfg_rdata_i;
		v = cfg_rvalid_i;
	endtask
endmodule // hcb_cfg_src

// ===== sim/tb_top.sv
// Self-checking bench for the configuration bank slice.
// Assumes the configuration source model drives the access port; ce is held high except during one identifier write.
`timescale 1ns/1ps
module tb_top;
	// Identifier defaults; these values are arbitrary
	localparam logic [7:0] SID_LO = 8'h5A;
	localparam logic [7:0] SID_HI = 8'hA5;
	localparam logic [7:0] BB_LO = 8'h3C;
	logic clk_sys_i;
	logic rstn_i;
	logic ce_i;
	hcb_pkg::hcb_cfg_req_s cfg_req;
	logic [7:0] rdata;
	logic rvalid;
	logic [7:0] fuse;
	logic ovr;
	logic ee_busy;
	logic host_slow;
	logic ee_slow;
	logic [10:0] scl;
	logic ss_sup;
	logic ss_adv;
	logic ss_en;
	logic [3:0] port_used;
	logic [3:0] mask;
	logic [3:0] port_ss;
	logic auto_en;
	logic [3:0] chg_start;
	logic [3:0] chg_step;
	logic [3:0] chg_stop;
	hcb_pkg::hcb_chg_e [3:0] chg_mode;
	logic [15:0] sid;
	logic [7:0] bb_lo;
	int err_total = 0;
	int n_tests = 0;

	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	hcb_bank #(.SID_LO_RST(SID_LO), .SID_HI_RST(SID_HI), .BBPID_LO_RST(BB_LO)) i_hcb_bank (
		.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i),
		.cfg_req_i(cfg_req), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
		.fuse_bits_i(fuse), .custom_removable_override_i(ovr),
		.eeprom_busy_i(ee_busy), .host_xfer_slow_o(host_slow),
		.eeprom_xfer_slow_o(ee_slow), .scl_half_cycles_o(scl),
		.hub_superspeed_suppress_o(ss_sup), .ss_speed_advertise_o(ss_adv),
		.ss_hub_enable_o(ss_en), .port_used_i(port_used),
		.port_legacy_only_mask_o(mask), .port_ss_enable_o(port_ss),
		.auto_charge_en_i(auto_en), .chg_start_i(chg_start), .chg_step_i(chg_step),
		.chg_stop_i(chg_stop), .chg_mode_o(chg_mode),
		.alt_mode_sid_o(sid), .billboard_product_low_o(bb_lo)
	);

	hcb_cfg_src i_hcb_cfg_src (
		.clk_sys_i(clk_sys_i), .cfg_req_o(cfg_req), .cfg_rdata_i(rdata), .cfg_rvalid_i(rvalid)
	);

	task automatic stop_test();
		$display("Checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic v;
		i_hcb_cfg_src.rd(a, d, v);
		chk("read valid", {15'h0000, v}, 16'h0001);
		chk($sformatf("read %h", a), {8'h00, d}, {8'h00, exp});
	endtask

	// Feature outputs trail the register by one cycle, so two edges are allowed
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	// Bit 0 start, bit 1 step, bit 2 stop, all as one-cycle pulses on port 0
	task automatic chg(input logic [2:0] k, input hcb_pkg::hcb_chg_e exp);
		@(posedge clk_sys_i);
		chg_start <= {3'h0, k[0]};
		chg_step <= {3'h0, k[1]};
		chg_stop <= {3'h0, k[2]};
		@(posedge clk_sys_i);
		chg_start <= 4'h0;
		chg_step <= 4'h0;
		chg_stop <= 4'h0;
		#1;
		chk("charge mode", {10'h000, chg_mode[0]}, {10'h000, exp});
	endtask

	initial begin
		#20000;
		err_total++;
		$display("MISMATCH watchdog expected done seen hang");
		stop_test();
	end

	initial begin
		rstn_i = 1'b0;
		ce_i = 1'b1;
		fuse = 8'h00;
		ovr = 1'b0;
		ee_busy = 1'b0;
		port_used = 4'h0;
		auto_en = 1'b0;
		chg_start = 4'h0;
		chg_step = 4'h0;
		chg_stop = 4'h0;
		repeat (3) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		rd_chk(8'h25, 8'h00);
		rd_chk(8'h26, 8'h00);
		rd_chk(8'h27, SID_LO);
		rd_chk(8'h28, SID_HI);
		rd_chk(8'h29, BB_LO);
		rd_chk(8'h30, 8'h00);
		chk("sid", sid, {SID_HI, SID_LO});
		$display("Test reset values done");
		i_hcb_cfg_src.wr(8'h25, 8'hFF);
		rd_chk(8'h25, 8'h17);
		wait_cyc(2);
		chk("suppress", {15'h0000, ss_sup}, 16'h0001);
		chk("advertise", {15'h0000, ss_adv}, 16'h0000);
		chk("ss hub", {15'h0000, ss_en}, 16'h0000);
		chk("host slow", {15'h0000, host_slow}, 16'h0001);
		chk("scl host", {5'h00, scl}, 16'h03E8);
		@(posedge clk_sys_i);
		ee_busy <= 1'b1;
		wait_cyc(2);
		chk("eeprom slow", {15'h0000, ee_slow}, 16'h0000);
		chk("scl eeprom", {5'h00, scl}, 16'h00FA);
		i_hcb_cfg_src.wr(8'h25, 8'h00);
		@(posedge clk_sys_i);
		fuse <= 8'hFF;
		wait_cyc(2);
		chk("eeprom slow fuse", {15'h0000, ee_slow}, 16'h0001);
		chk("scl fuse", {5'h00, scl}, 16'h03E8);
		rd_chk(8'h25, 8'h17);
		i_hcb_cfg_src.wr(8'h25, 8'h00);
		rd_chk(8'h25, 8'h17);
		@(posedge clk_sys_i);
		fuse <= 8'h00;
		ee_busy <= 1'b0;
		wait_cyc(2);
		rd_chk(8'h25, 8'h00);
		$display("Test config register done");
		@(posedge clk_sys_i);
		port_used <= 4'hF;
		i_hcb_cfg_src.wr(8'h26, 8'h0F);
		rd_chk(8'h26, 8'h00);
		wait_cyc(2);
		chk("port ss", {12'h000, port_ss}, 16'h000F);
		@(posedge clk_sys_i);
		ovr <= 1'b1;
		i_hcb_cfg_src.wr(8'h26, 8'hFA);
		rd_chk(8'h26, 8'h0A);
		wait_cyc(2);
		chk("mask", {12'h000, mask}, 16'h000A);
		chk("port ss", {12'h000, port_ss}, 16'h0005);
		$display("Test legacy mask done");
		i_hcb_cfg_src.wr(8'h27, 8'hAB);
		i_hcb_cfg_src.wr(8'h28, 8'hCD);
		i_hcb_cfg_src.wr(8'h29, 8'hEF);
		// A write while the enable is low must leave the byte alone
		@(posedge clk_sys_i);
		ce_i <= 1'b0;
		i_hcb_cfg_src.wr(8'h27, 8'h11);
		ce_i <= 1'b1;
		rd_chk(8'h27, 8'hAB);
		rd_chk(8'h28, 8'hCD);
		chk("sid", sid, 16'hCDAB);
		chk("bb pid", {8'h00, bb_lo}, 16'h00EF);
		// Mid-run reset must bring the defaults back
		@(posedge clk_sys_i);
		rstn_i <= 1'b0;
		@(posedge clk_sys_i);
		rstn_i <= 1'b1;
		#1;
		chk("sid reset", sid, {SID_HI, SID_LO});
		chk("bb pid reset", {8'h00, bb_lo}, {8'h00, BB_LO});
		chk("mask reset", {12'h000, mask}, 16'h0000);
		$display("Test identifiers done");
		@(posedge clk_sys_i);
		auto_en <= 1'b1;
		i_hcb_cfg_src.wr(8'h25, 8'h01);
		wait_cyc(2);
		chg(3'b001, hcb_pkg::CHG_DIV3);
		chg(3'b010, hcb_pkg::CHG_DIV2);
		chg(3'b010, hcb_pkg::CHG_DIV1);
		chg(3'b010, hcb_pkg::CHG_VEND);
		chg(3'b010, hcb_pkg::CHG_DCP);
		chg(3'b100, hcb_pkg::CHG_IDLE);
		i_hcb_cfg_src.wr(8'h25, 8'h03);
		wait_cyc(2);
		chg(3'b001, hcb_pkg::CHG_DIV3);
		chg(3'b010, hcb_pkg::CHG_DIV2);
		chg(3'b010, hcb_pkg::CHG_DIV1);
		chg(3'b010, hcb_pkg::CHG_DCP);
		chg(3'b100, hcb_pkg::CHG_IDLE);
		i_hcb_cfg_src.wr(8'h25, 8'h02);
		wait_cyc(2);
		chg(3'b001, hcb_pkg::CHG_DCP);
		chg(3'b100, hcb_pkg::CHG_IDLE);
		i_hcb_cfg_src.wr(8'h25, 8'h00);
		wait_cyc(2);
		chg(3'b001, hcb_pkg::CHG_VEND);
		i_hcb_cfg_src.wr(8'h25, 8'h02);
		wait_cyc(2);
		chk("vendor exit", {10'h000, chg_mode[0]}, {10'h000, hcb_pkg::CHG_DCP});
		@(posedge clk_sys_i);
		auto_en <= 1'b0;
		wait_cyc(2);
		chk("auto off", {10'h000, chg_mode[0]}, {10'h000, hcb_pkg::CHG_IDLE});
		$display("Test charger sequence done");
		stop_test();
	end
endmodule // tb_top
